//--- design/clk_mon_pkg.sv
// constants and carrier types for the clock status and pll monitor bank
// assumes a register port inside the device gives address, write and read strobes
// How it works
// - bit 4 latches a master clock halt and clears on read.
// - bit 0 latches any clock error and clears on read.
// - bit 2 reads 1 only while frame and bit clocks are both low.
// - bit 1 shows live resynchronization activity, not latched.
// - monitors show auto derived values when auto setup is on, else programmed.
// - p view in bits 6..0 holds divider minus one.
// - j view in bits 5..0 holds j directly, zero meaning error.
// - d view split: upper bits 5..0 first register, lower part second register.
// - combined d is 0 to 9999; larger values signal an error.
package clk_mon_pkg;
	localparam logic [7:0] CLOCK_FAULT_STATUS_OFS = 8'h5F;
	localparam logic [7:0] PLL_P_MONITOR_OFS      = 8'h60;
	localparam logic [7:0] PLL_J_MONITOR_OFS      = 8'h61;
	localparam logic [7:0] PLL_D_MONITOR_HIGH_OFS = 8'h62;
	localparam logic [7:0] PLL_D_MONITOR_LOW_OFS  = 8'h63;
	localparam int HALT_BIT   = 4;
	localparam int ABSENT_BIT = 2;
	localparam int RESYNC_BIT = 1;
	localparam int FAULT_BIT  = 0;
	localparam int D_LOW_BIT  = 5;
	localparam logic [7:0]  STATUS_RSVD_MASK = 8'hE8;
	localparam logic [7:0]  P_RSVD_MASK      = 8'h80;
	localparam logic [7:0]  J_RSVD_MASK      = 8'hC0;
	localparam logic [7:0]  D_HIGH_RSVD_MASK = 8'hC0;
	localparam logic [7:0]  D_LOW_RSVD_MASK  = 8'hC0;
	localparam logic [7:0]  RSVD_RESET       = 8'h00;
	localparam logic [13:0] D_MAX            = 14'h270F;
	localparam logic [3:0]  ABSENT_WINDOW    = 4'hF;

	typedef struct packed {
		logic [6:0] p_code;
		logic [5:0] j_code;
		logic [6:0] d_value;
	} pll_factors_t;

	typedef struct packed {
		logic       halt_event;
		logic       fault_event;
		logic       frame_clk;
		logic       bit_clk;
		logic       resync_busy;
	} clk_events_t;
endpackage : clk_mon_pkg

//--- design/clock_status_pll_monitor_regs.sv
// clock fault status and pll monitor registers, offsets 0x5F to 0x63
// assumes events and factors come from logic on core_clk except the serial clock pins
`timescale 1ns/1ns
module clock_status_pll_monitor_regs (
	input  wire logic                     core_clk,     // register clock, 100 MHz
	input  wire logic                     rst,          // synchronous reset, active high
	input  wire logic [7:0]               reg_addr,     // register offset
	input  wire logic                     reg_wr,       // write strobe, one cycle
	input  wire logic [7:0]               reg_wdata,    // write data
	input  wire logic                     reg_rd,       // read strobe, one cycle
	output logic      [7:0]               reg_rdata,    // read data, valid cycle after reg_rd
	input  wire clk_mon_pkg::clk_events_t evt,          // clock events and pin levels
	input  wire logic                     auto_set_en,  // automatic clock setup active
	input  wire clk_mon_pkg::pll_factors_t auto_factors, // auto derived factors
	input  wire clk_mon_pkg::pll_factors_t prog_factors, // software programmed factors
	output logic                          d_error       // combined d out of range
);
	// ==========================================================
	// pin synchronisers
	logic [1:0] frame_sync_reg;
	logic [1:0] bit_sync_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frame_sync_reg <= 2'h0;
			bit_sync_reg   <= 2'h0;
		end else begin
			frame_sync_reg <= {frame_sync_reg[0], evt.frame_clk};
			bit_sync_reg   <= {bit_sync_reg[0], evt.bit_clk};
		end
	end

	// ==========================================================
	// serial clock absence: both low for a full window of samples
	// frame and bit clocks both idling low longer than the sixteen-sample window read as absent;
	// short window trades false absence at slow clocks for fast reporting
	logic [3:0] low_cnt_reg;
	logic       absent_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			low_cnt_reg <= 4'h0;
			absent_reg  <= 1'b0;
		end else if (frame_sync_reg[1] | bit_sync_reg[1]) begin
			low_cnt_reg <= 4'h0;
			absent_reg  <= 1'b0;
		end else if (low_cnt_reg != clk_mon_pkg::ABSENT_WINDOW) begin
			low_cnt_reg <= low_cnt_reg + 4'h1;
		end else begin
			absent_reg <= 1'b1;
		end
	end

	// ==========================================================
	// sticky flags
	logic halt_reg;
	logic fault_reg;
	logic rd_status;
	assign rd_status = reg_rd && (reg_addr == clk_mon_pkg::CLOCK_FAULT_STATUS_OFS);
	always_ff @(posedge core_clk) begin
		if (rst)
			halt_reg <= 1'b0;
		else if (evt.halt_event)
			halt_reg <= 1'b1;
		else if (rd_status)
			halt_reg <= 1'b0;
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			fault_reg <= 1'b0;
		else if (evt.fault_event)
			fault_reg <= 1'b1;
		else if (rd_status)
			fault_reg <= 1'b0;
	end

	// ==========================================================
	// reserved bits: storage only
	logic [7:0] rsvd_reg [5];
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 5; i++)
				rsvd_reg[i] <= clk_mon_pkg::RSVD_RESET;
		end else if (reg_wr && reg_addr >= clk_mon_pkg::CLOCK_FAULT_STATUS_OFS
				&& reg_addr <= clk_mon_pkg::PLL_D_MONITOR_LOW_OFS) begin
			rsvd_reg[3'(reg_addr - clk_mon_pkg::CLOCK_FAULT_STATUS_OFS)] <= reg_wdata;
		end
	end

	// ==========================================================
	// factor selection
	clk_mon_pkg::pll_factors_t used;
	logic [13:0]               d_full;
	assign used = auto_set_en ? auto_factors : prog_factors;
	// combined d value
	// only seven d bits reach the registers, so the range guard cannot trip today
	assign d_full = {7'h00, used.d_value};
	always_ff @(posedge core_clk) begin
		if (rst)
			d_error <= 1'b0;
		else
			d_error <= (d_full > clk_mon_pkg::D_MAX);
	end

	// ==========================================================
	// read mux, data registered
	function automatic logic [7:0] rmask(input logic [7:0] r, input logic [7:0] m);
		return r & m;
	endfunction : rmask
	always_ff @(posedge core_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				clk_mon_pkg::CLOCK_FAULT_STATUS_OFS: reg_rdata <=
					rmask(rsvd_reg[0], clk_mon_pkg::STATUS_RSVD_MASK)
					| (8'(halt_reg) << clk_mon_pkg::HALT_BIT)
					| (8'(absent_reg) << clk_mon_pkg::ABSENT_BIT)
					| (8'(evt.resync_busy) << clk_mon_pkg::RESYNC_BIT)
					| (8'(fault_reg) << clk_mon_pkg::FAULT_BIT);
				clk_mon_pkg::PLL_P_MONITOR_OFS: reg_rdata <=
					rmask(rsvd_reg[1], clk_mon_pkg::P_RSVD_MASK) | {1'b0, used.p_code};
				clk_mon_pkg::PLL_J_MONITOR_OFS: reg_rdata <=
					rmask(rsvd_reg[2], clk_mon_pkg::J_RSVD_MASK) | {2'h0, used.j_code};
				clk_mon_pkg::PLL_D_MONITOR_HIGH_OFS: reg_rdata <=
					rmask(rsvd_reg[3], clk_mon_pkg::D_HIGH_RSVD_MASK) | {2'h0, used.d_value[6:1]};
				clk_mon_pkg::PLL_D_MONITOR_LOW_OFS: reg_rdata <=
					rmask(rsvd_reg[4], clk_mon_pkg::D_LOW_RSVD_MASK)
					| (8'(used.d_value[0]) << clk_mon_pkg::D_LOW_BIT);
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// checks
	sequence s_status_read;
		reg_rd && reg_addr == clk_mon_pkg::CLOCK_FAULT_STATUS_OFS;
	endsequence
	property p_halt_set;
		@(posedge core_clk) disable iff (rst) evt.halt_event |=> halt_reg;
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("halt not latched");
	property p_fault_set;
		@(posedge core_clk) disable iff (rst) evt.fault_event |=> fault_reg;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not latched");
	property p_clear_on_read;
		@(posedge core_clk) disable iff (rst)
			s_status_read ##0 !evt.fault_event |=> !fault_reg;
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("fault not cleared");
	property p_absent_low;
		@(posedge core_clk) disable iff (rst) (frame_sync_reg[1] | bit_sync_reg[1]) |=> !absent_reg;
	endproperty
	a_absent_low: assert property (p_absent_low) else $error("absent with clock present");
	property p_resync_live;
		@(posedge core_clk) disable iff (rst) s_status_read |=> reg_rdata[1] == $past(evt.resync_busy);
	endproperty
	a_resync_live: assert property (p_resync_live) else $error("resync bit wrong");
	property p_p_view;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == clk_mon_pkg::PLL_P_MONITOR_OFS |=> reg_rdata[6:0] == $past(used.p_code);
	endproperty
	a_p_view: assert property (p_p_view) else $error("p view wrong");
	property p_j_view;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == clk_mon_pkg::PLL_J_MONITOR_OFS && auto_set_en
			|=> reg_rdata[5:0] == $past(auto_factors.j_code);
	endproperty
	a_j_view: assert property (p_j_view) else $error("j view not auto");
	property p_rsvd_zero;
		@(posedge core_clk) disable iff (rst)
			$fell(rst) |-> rsvd_reg[0] == clk_mon_pkg::RSVD_RESET
				&& rsvd_reg[1] == clk_mon_pkg::RSVD_RESET
				&& rsvd_reg[2] == clk_mon_pkg::RSVD_RESET
				&& rsvd_reg[3] == clk_mon_pkg::RSVD_RESET
				&& rsvd_reg[4] == clk_mon_pkg::RSVD_RESET;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not cleared by reset");
	property p_d_low;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == clk_mon_pkg::PLL_D_MONITOR_LOW_OFS |=> reg_rdata[5] == $past(used.d_value[0]);
	endproperty
	a_d_low: assert property (p_d_low) else $error("d low bit wrong");
	property p_ro_ignored;
		@(posedge core_clk) disable iff (rst)
			reg_wr && reg_addr == clk_mon_pkg::PLL_P_MONITOR_OFS && !auto_set_en ##1
			reg_rd && reg_addr == clk_mon_pkg::PLL_P_MONITOR_OFS && !auto_set_en
			|=> reg_rdata[6:0] == $past(prog_factors.p_code);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("write reached read-only field");
	property p_d_range;
		@(posedge core_clk) disable iff (rst) 1'b1 |=> d_error == $past(d_full > clk_mon_pkg::D_MAX);
	endproperty
	a_d_range: assert property (p_d_range) else $error("d error missed");
	property p_halt_clear;
		@(posedge core_clk) disable iff (rst)
			s_status_read ##0 !evt.halt_event |=> !halt_reg;
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");
	property p_absent_window;
		@(posedge core_clk) disable iff (rst)
			$rose(absent_reg) |-> $past(low_cnt_reg) == clk_mon_pkg::ABSENT_WINDOW;
	endproperty
	a_absent_window: assert property (p_absent_window) else $error("absence reported early");
	property p_j_prog;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == clk_mon_pkg::PLL_J_MONITOR_OFS && !auto_set_en
			|=> reg_rdata[5:0] == $past(prog_factors.j_code);
	endproperty
	a_j_prog: assert property (p_j_prog) else $error("j view not programmed");
	property p_d_high;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == clk_mon_pkg::PLL_D_MONITOR_HIGH_OFS
			|=> reg_rdata[5:0] == $past(used.d_value[6:1]);
	endproperty
	a_d_high: assert property (p_d_high) else $error("d high bits wrong");
	property p_unmapped_zero;
		@(posedge core_clk) disable iff (rst)
			reg_rd && (reg_addr < clk_mon_pkg::CLOCK_FAULT_STATUS_OFS
				|| reg_addr > clk_mon_pkg::PLL_D_MONITOR_LOW_OFS)
			|=> reg_rdata == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule : clock_status_pll_monitor_regs

//--- testbench/test_clock_status_pll_monitor_regs.sv
// self-checking bench for the clock status and pll monitor registers
// assumes the design answers a read one cycle after reg_rd; inputs change at falling edges
`timescale 1ns/1ns
module test_clock_status_pll_monitor_regs;
	logic                      core_clk = 1'b0;
	logic                      rst = 1'b1;
	logic [7:0]                reg_addr = 8'h00;
	logic                      reg_wr = 1'b0;
	logic [7:0]                reg_wdata = 8'h00;
	logic                      reg_rd = 1'b0;
	logic [7:0]                reg_rdata;
	clk_mon_pkg::clk_events_t  evt = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic                      auto_set_en = 1'b1;
	clk_mon_pkg::pll_factors_t auto_factors = '{7'h7F, 6'h3F, 7'h7F};
	clk_mon_pkg::pll_factors_t prog_factors = '{7'h00, 6'h00, 7'h41};
	logic                      d_error;
	int                        mismatches = 0;
	int                        checks_done = 0;

	always #5 core_clk = ~core_clk;

	clock_status_pll_monitor_regs i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .auto_set_en(auto_set_en),
		.auto_factors(auto_factors), .prog_factors(prog_factors), .d_error(d_error));

	// ==========================================
	// bus cycles and comparison
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk(n, e, reg_rdata);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// ==========================================
	// scenarios
	task automatic sc_latched_flags();
		@(negedge core_clk);
		evt.halt_event = 1'b1;
		@(negedge core_clk);
		evt.halt_event = 1'b0;
		rd(8'h5F, 8'h10, "halt latched");
		rd(8'h5F, 8'h00, "halt cleared");
		@(negedge core_clk);
		evt.fault_event = 1'b1;
		@(negedge core_clk);
		evt.fault_event = 1'b0;
		rd(8'h5F, 8'h01, "fault latched");
		// event in the read cycle must survive the clear
		@(negedge core_clk);
		reg_addr = 8'h5F;
		reg_rd = 1'b1;
		evt.fault_event = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		evt.fault_event = 1'b0;
		rd(8'h5F, 8'h01, "fault kept");
		rd(8'h5F, 8'h00, "fault cleared");
	endtask : sc_latched_flags

	task automatic sc_live_status();
		evt.resync_busy = 1'b1;
		rd(8'h5F, 8'h02, "resync live");
		evt.resync_busy = 1'b0;
		rd(8'h5F, 8'h00, "resync gone");
		evt.frame_clk = 1'b0;
		repeat (30) @(negedge core_clk);
		rd(8'h5F, 8'h00, "one pin low");
		evt.bit_clk = 1'b0;
		repeat (30) @(negedge core_clk);
		rd(8'h5F, 8'h04, "both low");
		evt.bit_clk = 1'b1;
		repeat (5) @(negedge core_clk);
		rd(8'h5F, 8'h00, "bit clock back");
		evt.frame_clk = 1'b1;
	endtask : sc_live_status

	task automatic sc_factor_views();
		auto_set_en = 1'b1;
		rd(8'h60, 8'h7F, "p auto");
		rd(8'h61, 8'h3F, "j auto");
		rd(8'h62, 8'h3F, "d high auto");
		rd(8'h63, 8'h20, "d low auto");
		chk("d range", 8'h00, {7'h00, d_error});
		auto_set_en = 1'b0;
		rd(8'h60, 8'h00, "p prog");
		rd(8'h61, 8'h00, "j prog");
		rd(8'h62, 8'h20, "d high prog");
		rd(8'h63, 8'h20, "d low prog");
	endtask : sc_factor_views

	task automatic sc_reserved_writes();
		wr(8'h5F, 8'hFF);
		// write then read back to back: read-only field must not move
		@(negedge core_clk);
		reg_addr = 8'h60;
		reg_wdata = 8'hFF;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk("p after write", 8'h80, reg_rdata);
		wr(8'h61, 8'hFF);
		wr(8'h62, 8'hFF);
		wr(8'h63, 8'hFF);
		rd(8'h5F, 8'hE8, "status rsvd");
		rd(8'h60, 8'h80, "p rsvd");
		rd(8'h61, 8'hC0, "j rsvd");
		rd(8'h62, 8'hE0, "d high rsvd");
		rd(8'h63, 8'hE0, "d low rsvd");
		rd(8'h70, 8'h00, "unmapped");
	endtask : sc_reserved_writes

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		rd(8'h5F, 8'h00, "status reset");
		sc_latched_flags();
		sc_live_status();
		sc_factor_views();
		sc_reserved_writes();
		summarize();
	end

	// cuts a hang short
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
endmodule : test_clock_status_pll_monitor_regs
